// *** bench/switch_model.sv ***
// far-side model: the bank of mechanical switches seen through the comparators
// assumes: the bench sets the contact states; they reach the design unsynchronised
`default_nettype none

module switch_model (
  output logic [23:0] comp_raw_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial comp_raw_out = 24'h000000;

  // contacts change at any time, with no regard to the design clock
  task automatic set_state(input logic [23:0] v);
    comp_raw_out = v;
  endtask
endmodule

`default_nettype wire

// *** bench/tb_switch_cfg.sv ***
// self-checking bench for the switch-input configuration block
// assumes: switch_model beside it; inputs change 1 ns after the rising clock edge
`default_nettype none

module tb_switch_cfg
  import sw_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // short unit keeps each pulse a few cycles long
  localparam int UNIT = 4;

  logic        core_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [23:0] reg_wdata_in = 24'h000000;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        pulse_mode_in = 1'b0;
  logic        sample_start_in = 1'b0;
  logic [23:0] comp_raw, reg_rdata_out, level_sel_out, pulse_drive_out, switch_state_out, edge_event_out;
  logic [23:0] ev, pulse_seen;
  logic        reg_rvalid_out, busy_out, sample_done_out;
  cfg_t        active_cfg_out;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          pulse_cycles;
  logic [23:0] sw_tab [3] = '{24'h001005, 24'h000002, 24'h000000};
  logic [23:0] ev_tab [3] = '{24'h001005, 24'h000004, 24'h000002};

  switch_model u_sw (.comp_raw_out(comp_raw));

  switch_cfg #(.PULSE_UNIT_CYCLES(UNIT)) u_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .pulse_mode_in(pulse_mode_in),
    .sample_start_in(sample_start_in), .comp_raw_in(comp_raw), .active_cfg_out(active_cfg_out),
    .level_sel_out(level_sel_out), .pulse_drive_out(pulse_drive_out), .busy_out(busy_out),
    .switch_state_out(switch_state_out), .edge_event_out(edge_event_out),
    .sample_done_out(sample_done_out));

  initial forever #10 core_clk_in = ~core_clk_in;

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [86:0] exp, input logic [86:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge core_clk_in);
    #1;
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    reg_wr_in = 1'b0;
  endtask

  // read data and valid are registered at the read edge and stand for the cycle after it
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [23:0] exp);
    @(posedge core_clk_in);
    #1;
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    reg_rd_in = 1'b0;
    chk("rvalid", 1'b1, reg_rvalid_out);
    chk(what, exp, reg_rdata_out);
  endtask

  // one sampling run; counts the cycles the cleaning pulse stands
  task automatic sample();
    @(posedge core_clk_in);
    #1;
    sample_start_in = 1'b1;
    @(posedge core_clk_in);
    #1;
    sample_start_in = 1'b0;
    pulse_cycles = 0;
    pulse_seen = 24'h000000;
    for (int k = 0; k < 200; k++) begin
      if (sample_done_out === 1'b1) break;
      if (pulse_drive_out !== 24'h000000) begin
        pulse_cycles++;
        pulse_seen = pulse_drive_out;
      end
      @(posedge core_clk_in);
      #1;
    end
    chk("sample_done", 1'b1, sample_done_out);
    ev = edge_event_out;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("ERROR cycle_limit expected %0d seen %0d", 4999, cycles);
      finish_test();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge core_clk_in);
    #1;
    sys_rst_in = 1'b0;
    chk("level_sel_rst", 24'h111111, level_sel_out);
    rd_chk("pulse_en_rst", 8'h20, 24'h000000);
    rd_chk("thresh_rst", 8'h21, 24'h000000);
    wr(8'h20, 24'hA5C3F0);
    rd_chk("pulse_en", 8'h20, 24'hA5C3F0);
    wr(8'h21, 24'hABCDE4);
    rd_chk("thresh_reserved", 8'h21, 24'h000DE4);
    rd_chk("unmapped", 8'h40, 24'h000000);
    for (int c = 0; c < 4; c++) begin
      wr(8'h21, 24'(c * 12'h555));
      sample();
      chk("level_sel_code", 24'h111111 << c, level_sel_out);
    end
    wr(8'h21, 24'h0001E4);
    sample();
    chk("level_sel_groups", 24'h128421, level_sel_out);
    // pulse of three units; a threshold write lands while busy
    pulse_mode_in = 1'b1;
    wr(8'h1F, 24'h000020);
    fork
      sample();
      begin
        repeat (3) @(posedge core_clk_in);
        wr(8'h21, 24'h000FFF);
      end
    join
    chk("pulse_len", 3 * UNIT, pulse_cycles);
    chk("pulse_inputs", 24'hA5C3F0, pulse_seen);
    chk("thresh_in_use", 12'h1E4, active_cfg_out.thresh);
    wr(8'h1F, 24'hFFFFFF);
    rd_chk("pulse_time", 8'h1F, 24'h000070);
    sample();
    chk("pulse_len_max", 8 * UNIT, pulse_cycles);
    chk("level_sel_next", 24'h888888, level_sel_out);
    pulse_mode_in = 1'b0;
    wr(8'h22, 24'h000039);
    wr(8'h23, 24'h000001);
    for (int i = 0; i < 3; i++) begin
      u_sw.set_state(sw_tab[i]);
      repeat (3) @(posedge core_clk_in);
      sample();
      chk("switch_state", sw_tab[i], switch_state_out);
      chk("edge_event", ev_tab[i], ev);
    end
    finish_test();
  end
endmodule

`default_nettype wire

// *** core/pulse_timer.sv ***
// timer for the cleaning pulse: (code + 1) units of the unit length
// assumes: start_in is a one-cycle pulse on core_clk_in, not given while running
`include "sw_cfg_regs.svh"
`default_nettype none

module pulse_timer #(
  parameter int unsigned UNIT_CYCLES = `PULSE_UNIT_CYCLES
) (
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       start_in,
  input  wire logic [2:0] code_in,
  output logic            done_out
);

  logic [15:0] cyc;
  logic [2:0]  ticks;
  logic [2:0]  code_q;
  logic        running;

  wire unit_end = (cyc == 16'(UNIT_CYCLES - 1));
  wire last     = unit_end && (ticks == code_q);

  assign done_out = running && last;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      running <= 1'b0;
      cyc     <= 16'h0000;
      ticks   <= 3'h0;
      code_q  <= 3'h0;
    end else if (start_in) begin
      running <= 1'b1;
      cyc     <= 16'h0000;
      ticks   <= 3'h0;
      code_q  <= code_in;
    end else if (running) begin
      if (unit_end) begin
        cyc <= 16'h0000;
        if (last) running <= 1'b0;
        else ticks <= ticks + 3'h1;
      end else begin
        cyc <= cyc + 16'h0001;
      end
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  timer_done_gated_a : assert property (done_out |=> !running && !done_out)
    else $error("pulse timer still running after its last unit");

endmodule

`default_nettype wire

// *** core/sw_cfg_pkg.sv ***
// types shared by the switch-input configuration block
// assumes: sw_cfg_regs.svh on the include path
`include "sw_cfg_regs.svh"
`default_nettype none

package sw_cfg_pkg;

  typedef struct packed {
    logic [`INT_EN_W-1:0]    int_en;
    logic [`DUR_W-1:0]       dur;
    logic [`THRESH_W-1:0]    thresh;
    logic [`INPUT_COUNT-1:0] pulse_en;
  } cfg_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b001,
    S_PULSE  = 3'b010,
    S_SAMPLE = 3'b100
  } samp_state_t;

endpackage

`default_nettype wire

// *** core/sw_cfg_regs.svh ***
// register offsets, field positions, reset values and timing figures of the switch-input configuration block
// assumes: included by bare name from the package and the design modules
`ifndef SW_CFG_REGS_SVH
`define SW_CFG_REGS_SVH

`define INPUT_COUNT        24
`define GROUP_COUNT        6
`define THRESH_W           12
`define INT_EN_W           48
`define DUR_W              3

`define OFF_PULSE_TIME     8'h1F
`define OFF_PULSE_EN       8'h20
`define OFF_THRESH         8'h21
`define OFF_INT_EN_LO      8'h22
`define OFF_INT_EN_HI      8'h23

`define DUR_LSB            4
`define WORD_ZERO          24'h000000
`define THRESH_RST         12'h000
`define INT_EN_RST         48'h000000000000
`define DUR_RST            3'h0

`define PULSE_UNIT_US      64
`define CLK_MHZ            50
`define PULSE_UNIT_CYCLES  (`PULSE_UNIT_US * `CLK_MHZ)

`endif

// *** core/switch_cfg.sv ***
// pulse-current enables, comparator thresholds and sampling of a 24-input switch monitor
// assumes: register port and sample_start_in on core_clk_in; comp_raw_in from the analog comparators
//
// Operation
// - one pulse enable bit per input
// - six 2-bit threshold fields, four inputs each
// - codes 0..3 select 2, 2.7, 3, 4 V
// - threshold bits 23..12 read zero, ignore writes
// - both registers reset to zero
// - pulse lasts 64 us times code plus one
// - per-input interrupt on rise, fall or both
`include "sw_cfg_regs.svh"
`default_nettype none

module switch_cfg
  import sw_cfg_pkg::*;
#(
  parameter int unsigned PULSE_UNIT_CYCLES = `PULSE_UNIT_CYCLES
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    sys_rst_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [23:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [23:0]             reg_rdata_out,
  output logic                         reg_rvalid_out,
  input  wire logic                    pulse_mode_in,
  input  wire logic                    sample_start_in,
  input  wire logic [`INPUT_COUNT-1:0] comp_raw_in,
  output cfg_t                         active_cfg_out,
  output logic      [`INPUT_COUNT-1:0] level_sel_out,
  output logic      [`INPUT_COUNT-1:0] pulse_drive_out,
  output logic                         busy_out,
  output logic      [`INPUT_COUNT-1:0] switch_state_out,
  output logic      [`INPUT_COUNT-1:0] edge_event_out,
  output logic                         sample_done_out
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  cfg_t cfg;

  wire hit_time   = (reg_addr_in == `OFF_PULSE_TIME);
  wire hit_pen    = (reg_addr_in == `OFF_PULSE_EN);
  wire hit_thresh = (reg_addr_in == `OFF_THRESH);
  wire hit_int_lo = (reg_addr_in == `OFF_INT_EN_LO);
  wire hit_int_hi = (reg_addr_in == `OFF_INT_EN_HI);

  // unmapped offsets read zero
  wire [23:0] rd_word =
    hit_time   ? {17'h00000, cfg.dur, 4'h0} :
    hit_pen    ? cfg.pulse_en :
    hit_thresh ? {12'h000, cfg.thresh} :
    hit_int_lo ? cfg.int_en[23:0] :
    hit_int_hi ? cfg.int_en[47:24] : `WORD_ZERO;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg.pulse_en <= `WORD_ZERO;
      cfg.thresh   <= `THRESH_RST;
      cfg.dur      <= `DUR_RST;
      cfg.int_en   <= `INT_EN_RST;
    end else if (reg_wr_in) begin
      if (hit_pen) cfg.pulse_en <= reg_wdata_in;
      if (hit_thresh) cfg.thresh <= reg_wdata_in[`THRESH_W-1:0];
      if (hit_time) cfg.dur <= reg_wdata_in[`DUR_LSB+:`DUR_W];
      if (hit_int_lo) cfg.int_en[23:0] <= reg_wdata_in;
      if (hit_int_hi) cfg.int_en[47:24] <= reg_wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out  <= `WORD_ZERO;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) reg_rdata_out <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // comparator input synchroniser
  // ----------------------------------------------------------------
  logic [`INPUT_COUNT-1:0] comp_meta;
  logic [`INPUT_COUNT-1:0] comp_sync;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      comp_meta <= `WORD_ZERO;
      comp_sync <= `WORD_ZERO;
    end else begin
      comp_meta <= comp_raw_in;
      comp_sync <= comp_meta;
    end
  end

  // ----------------------------------------------------------------
  // sampling sequence
  // ----------------------------------------------------------------
  samp_state_t state;
  logic        timer_done;

  wire start_ok    = (state == S_IDLE) && sample_start_in;
  wire want_pulse  = pulse_mode_in && (|cfg.pulse_en);
  wire timer_start = start_ok && want_pulse;

  pulse_timer #(
    .UNIT_CYCLES (PULSE_UNIT_CYCLES)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .start_in    (timer_start),
    .code_in     (cfg.dur),
    .done_out    (timer_done)
  );

  // per-input edge detection against the previous sample
  logic [`INPUT_COUNT-1:0] ev;

  genvar gi;
  generate
    for (gi = 0; gi < `INPUT_COUNT; gi++) begin : g_in
      wire rise = comp_sync[gi] & ~switch_state_out[gi];
      wire fall = ~comp_sync[gi] & switch_state_out[gi];
      assign ev[gi] = (active_cfg_out.int_en[2*gi] & rise) | (active_cfg_out.int_en[2*gi+1] & fall);
    end
    // one-hot level select per group: bit 0 = 2 V, 1 = 2.7 V, 2 = 3 V, 3 = 4 V
    for (gi = 0; gi < `GROUP_COUNT; gi++) begin : g_grp
      assign level_sel_out[4*gi+:4] = 4'h1 << active_cfg_out.thresh[2*gi+:2];
    end
  endgenerate

  assign busy_out = (state != S_IDLE);

  // settings are copied only when a sampling begins, so a write mid-sample cannot tear it
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state            <= S_IDLE;
      active_cfg_out   <= '0;
      pulse_drive_out  <= `WORD_ZERO;
      switch_state_out <= `WORD_ZERO;
      edge_event_out   <= `WORD_ZERO;
      sample_done_out  <= 1'b0;
    end else begin
      edge_event_out  <= `WORD_ZERO;
      sample_done_out <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (start_ok) begin
            active_cfg_out <= cfg;
            if (want_pulse) begin
              pulse_drive_out <= cfg.pulse_en;
              state           <= S_PULSE;
            end else begin
              state <= S_SAMPLE;
            end
          end
        end
        S_PULSE: begin
          if (timer_done) begin
            pulse_drive_out <= `WORD_ZERO;
            state           <= S_SAMPLE;
          end
        end
        S_SAMPLE: begin
          switch_state_out <= comp_sync;
          edge_event_out   <= ev;
          sample_done_out  <= 1'b1;
          state            <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  // helper: length of the current pulse
  logic [17:0] pulse_len;
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) pulse_len <= 18'h00000;
    else if (state == S_PULSE) pulse_len <= pulse_len + 18'h00001;
    else pulse_len <= 18'h00000;
  end
  wire [17:0] pulse_want = 18'((active_cfg_out.dur + 4'h1) * PULSE_UNIT_CYCLES);

  pulse_subset_a : assert property ((state == S_PULSE) |-> pulse_drive_out == active_cfg_out.pulse_en)
    else $error("pulse drive differs from enabled inputs");

  thresh_write_a : assert property (reg_wr_in && hit_thresh |=> cfg.thresh == $past(reg_wdata_in[11:0]))
    else $error("threshold write not stored");

  level_top_a : assert property ((active_cfg_out.thresh[11:10] == 2'h3) |-> level_sel_out[23:20] == 4'h8)
    else $error("top group level select wrong");

  thresh_resv_a : assert property (reg_rd_in && hit_thresh |=> reg_rvalid_out && reg_rdata_out[23:12] == 12'h000)
    else $error("reserved threshold bits read nonzero");

  reset_zero_a : assert property ($past(sys_rst_in) |-> cfg.thresh == `THRESH_RST && cfg.pulse_en == `WORD_ZERO)
    else $error("configuration not zero after reset");

  pulse_len_a : assert property ((state == S_PULSE) && timer_done |-> pulse_len + 18'h00001 == pulse_want)
    else $error("pulse length wrong");

  rise_event_a : assert property ((state == S_SAMPLE) && active_cfg_out.int_en[1:0] == 2'h1
                                  && comp_sync[0] && !switch_state_out[0] |=> edge_event_out[0] && sample_done_out)
    else $error("rising event on input 0 missed");

  cfg_hold_a : assert property ((state != S_IDLE) |=> $stable(active_cfg_out))
    else $error("active settings changed mid-sample");

endmodule

`default_nettype wire
